// ### hdl/sldm_defs.svh
`ifndef SLDM_DEFS_SVH
`define SLDM_DEFS_SVH

// register word indices on the plain port
`define SLDM_REG_CTRL        4'h0
`define SLDM_REG_Y_LEVELS    4'h1
`define SLDM_REG_C_LEVELS    4'h2
`define SLDM_REG_HTOTAL      4'h3
`define SLDM_REG_HSYNC_W     4'h4
`define SLDM_REG_ACT_START   4'h5
`define SLDM_REG_ACT_END     4'h6
`define SLDM_REG_STATUS      4'h7

// control field positions
`define SLDM_CTRL_MODE_LSB   0
`define SLDM_CTRL_PASSTHRU   2
`define SLDM_CTRL_RGB_OFS    3
`define SLDM_CTRL_SYNC_LSB   4
`define SLDM_CTRL_CSM_BYP    6
`define SLDM_CTRL_CLIP       7
`define SLDM_CTRL_FSADJ      8
`define SLDM_CTRL_WIDTH      9

// level word layout: blank, sync low, sync high
`define SLDM_LEV_BLANK_LSB   0
`define SLDM_LEV_LOW_LSB     10
`define SLDM_LEV_HIGH_LSB    20

// reset values
`define SLDM_CTRL_RST        9'h0c8
`define SLDM_Y_LEV_RST       30'h3c000040
`define SLDM_C_LEV_RST       30'h20080200
`define SLDM_HTOTAL_RST      12'h6b4
`define SLDM_HSYNC_W_RST     12'h07e
`define SLDM_ACT_START_RST   12'h0f4
`define SLDM_ACT_END_RST     12'h6a4

// 525-line interlaced preset
`define SLDM_FRAME_SIZE      10'h20d
`define SLDM_FIELD_SIZE      11'h107

// code range and dc offset
`define SLDM_CODE_MIN        10'h040
`define SLDM_CODE_Y_MAX      10'h3ac
`define SLDM_CODE_C_MAX      10'h3c0
`define SLDM_DAC_OFFSET      11'h100

`endif

// ### hdl/sldm_pkg.sv
package sldm_pkg;

   typedef enum logic [1:0] {SLDM_MODE_SD, SLDM_MODE_HD, SLDM_MODE_PC, SLDM_MODE_RSVD} sldm_mode_e;
   typedef enum logic [1:0] {SLDM_SYNC_NONE, SLDM_SYNC_ONE, SLDM_SYNC_ALL, SLDM_SYNC_RSVD} sldm_sync_e;

   typedef enum logic [3:0] {
      double_equalization_line,
      double_broad_sync_line,
      full_normal_sync_line,
      active_video_line,
      active_then_equalization_line,
      equalization_then_broad_line,
      broad_then_equalization_line,
      full_equalization_line,
      sync_then_active_line
   } sldm_line_e;

   typedef enum logic [1:0] {SLDM_PULSE_NONE, SLDM_PULSE_NORM, SLDM_PULSE_EQ, SLDM_PULSE_BROAD} sldm_pulse_e;

   typedef struct packed {
      logic [9:0] ch2;
      logic [9:0] ch1;
      logic [9:0] ch0;
   } sldm_video_s;

   typedef struct packed {
      logic [10:0] ch2;
      logic [10:0] ch1;
      logic [10:0] ch0;
   } sldm_dac_s;

   typedef struct packed {
      logic [9:0] high;
      logic [9:0] low;
      logic [9:0] blank;
   } sldm_levels_s;

endpackage

// ### hdl/sldm_top.sv
// Overview of operation
// R1: active video lines always forward input samples during the active state.
// R2: each line type runs from the previous breakpoint up to its own.
// R3: first field: eq, broad, eq, normal sync, active, active/eq.
// R4: second field: eq, eq/broad, broad, broad/eq, eq, full eq, sync, sync/active, active.
// R5: frame size is loaded with 525 lines.
// R6: field size is loaded with 263, the field boundary.
// R7: field one spans 263 lines, field two 262 lines.
// R8: non-video line types output generated levels unless pass-through is on.
// R9: pass-through forwards input video in active part of permitting line types.
// R10: pc graphics mode always drives dacs from the input bus.
// R11: override levels come from separate luma and chroma settings.
// R12: rgb setting adds the dc offset on all three channels.
// R13: luma/colour-difference setting offsets luma only; chroma code 0 is bottom.
// R14: source supplies colour-difference samples in offset binary.
// R15: three dac channels with 11-bit input path.
// R16: full-scale select chooses one of two output ranges.
// R17: in sync-inserted rgb modes code 64 is blank, 940 peak.
// R18: out-of-range codes are clipped or passed per matrix setting.
// R19: sync on green: tri-level in hd, bi-level in sd, channel 0 only.
// R20: sync on green: other channels hold blank during sync.
// R21: sync on all channels when programmed; same format on all three.
// R22: rgb without sync inserts none; separate hsync and vsync pins.
// R23: sync on luma inserts sync only on the luma channel.
// R24: colour-space matrix is bypassable for unmodified codes.
// R25: line counter wraps to 1 after the frame size.
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sldm_defs.svh"

module sldm_top
   import sldm_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic        rst_i,
   input  wire logic [3:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [31:0] reg_rdata_o,
   input  wire sldm_video_s video_i,
   output sldm_dac_s        dac_o,
   output logic             hsync_output_pin_o,
   output logic             vsync_output_pin_o,
   output logic             full_scale_sel_o
);

   // software registers, line-count presets and read data
   logic [8:0]   ctrl_q;
   logic [29:0]  y_lev_q;
   logic [29:0]  c_lev_q;
   logic [11:0]  htotal_q;
   logic [11:0]  hsync_w_q;
   logic [11:0]  act_start_q;
   logic [11:0]  act_end_q;
   logic [9:0]   frame_size_q;
   logic [10:0]  field_size_q;
   logic [31:0]  rdata_q;

   // timing state
   logic [11:0]  pix_q;
   logic [9:0]   line_q;
   sldm_dac_s    dac_q;
   logic         hsync_q;
   logic         vsync_q;

   wire         wr_ctrl   = reg_wr_i && (reg_addr_i == `SLDM_REG_CTRL);
   wire         wr_ylev   = reg_wr_i && (reg_addr_i == `SLDM_REG_Y_LEVELS);
   wire         wr_clev   = reg_wr_i && (reg_addr_i == `SLDM_REG_C_LEVELS);
   wire         wr_htot   = reg_wr_i && (reg_addr_i == `SLDM_REG_HTOTAL);
   wire         wr_hsw    = reg_wr_i && (reg_addr_i == `SLDM_REG_HSYNC_W);
   wire         wr_ast    = reg_wr_i && (reg_addr_i == `SLDM_REG_ACT_START);
   wire         wr_aen    = reg_wr_i && (reg_addr_i == `SLDM_REG_ACT_END);

   sldm_mode_e  mode;
   sldm_sync_e  sync_sel;
   assign mode     = sldm_mode_e'(ctrl_q[`SLDM_CTRL_MODE_LSB +: 2]);
   assign sync_sel = sldm_sync_e'(ctrl_q[`SLDM_CTRL_SYNC_LSB +: 2]);
   wire         passthru  = ctrl_q[`SLDM_CTRL_PASSTHRU];
   wire         rgb_ofs   = ctrl_q[`SLDM_CTRL_RGB_OFS];
   wire         csm_byp   = ctrl_q[`SLDM_CTRL_CSM_BYP];
   wire         clip_en   = ctrl_q[`SLDM_CTRL_CLIP];

   sldm_levels_s y_lev;
   sldm_levels_s c_lev;
   assign y_lev = sldm_levels_s'(y_lev_q);
   assign c_lev = sldm_levels_s'(c_lev_q);

   // -------- horizontal and line counters
   wire         pix_last  = (pix_q >= htotal_q - 12'h001);
   wire         line_last = (line_q >= frame_size_q);
   // R25: frame wrap
   wire [9:0]   line_nxt  = line_last ? 10'h001 : line_q + 10'h001;
   wire [11:0]  half      = {1'b0, htotal_q[11:1]};
   wire         second    = (pix_q >= half);
   wire [11:0]  hpos      = second ? pix_q - half : pix_q;
   wire         in_act    = (pix_q >= act_start_q) && (pix_q < act_end_q);
   // R7: field one ends at the field size line
   wire         field2    = ({1'b0, line_q} > field_size_q);

   // R2: breakpoint schedule, each entry up to but excluding its line
   function automatic sldm_line_e line_type(input logic [9:0] ln);
      // R3: first field
      if (ln < 10'h004)       line_type = double_equalization_line;
      else if (ln < 10'h007)  line_type = double_broad_sync_line;
      else if (ln < 10'h00a)  line_type = double_equalization_line;
      else if (ln < 10'h014)  line_type = full_normal_sync_line;
      else if (ln < 10'h107)  line_type = active_video_line;
      else if (ln < 10'h108)  line_type = active_then_equalization_line;
      // R4: second field
      else if (ln < 10'h10a)  line_type = double_equalization_line;
      else if (ln < 10'h10b)  line_type = equalization_then_broad_line;
      else if (ln < 10'h10d)  line_type = double_broad_sync_line;
      else if (ln < 10'h10e)  line_type = broad_then_equalization_line;
      else if (ln < 10'h110)  line_type = double_equalization_line;
      else if (ln < 10'h111)  line_type = full_equalization_line;
      else if (ln < 10'h11a)  line_type = full_normal_sync_line;
      else if (ln < 10'h11b)  line_type = sync_then_active_line;
      else                    line_type = active_video_line;
   endfunction

   function automatic sldm_pulse_e half_pulse(input sldm_line_e lt, input logic sec);
      unique case (lt)
         double_equalization_line:      half_pulse = SLDM_PULSE_EQ;
         double_broad_sync_line:        half_pulse = SLDM_PULSE_BROAD;
         active_then_equalization_line: half_pulse = sec ? SLDM_PULSE_EQ : SLDM_PULSE_NORM;
         equalization_then_broad_line:  half_pulse = sec ? SLDM_PULSE_BROAD : SLDM_PULSE_EQ;
         broad_then_equalization_line:  half_pulse = sec ? SLDM_PULSE_EQ : SLDM_PULSE_BROAD;
         full_equalization_line:        half_pulse = sec ? SLDM_PULSE_NONE : SLDM_PULSE_EQ;
         default:                       half_pulse = sec ? SLDM_PULSE_NONE : SLDM_PULSE_NORM;
      endcase
   endfunction

   sldm_line_e  ltype;
   sldm_pulse_e pulse;
   assign ltype = line_type(line_q);
   assign pulse = half_pulse(ltype, second);

   wire [11:0]  eq_w      = {1'b0, hsync_w_q[11:1]};
   wire [11:0]  broad_w   = half - hsync_w_q;
   wire         sync_low  = (pulse == SLDM_PULSE_NORM  && hpos < hsync_w_q) ||
                            (pulse == SLDM_PULSE_EQ    && hpos < eq_w) ||
                            (pulse == SLDM_PULSE_BROAD && hpos < broad_w);
   // tri-level positive excursion follows the normal pulse in hd only
   wire         sync_high = (mode == SLDM_MODE_HD) && (pulse == SLDM_PULSE_NORM) &&
                            (hpos >= hsync_w_q) && (hpos < {hsync_w_q[10:0], 1'b0});

   // R1: active lines always pass in the active state
   wire         pass_act  = (ltype == active_video_line) && in_act;
   // R9: permitting types pass only with pass-through on
   wire         pass_opt  = passthru && (ltype == full_normal_sync_line) && in_act;
   wire         pass_mix  = in_act &&
                            (((ltype == active_then_equalization_line) && !second) ||
                             ((ltype == sync_then_active_line) && second));
   // R10: pc mode never substitutes generated levels
   wire         use_video = (mode == SLDM_MODE_PC) || pass_act || pass_opt || pass_mix;

   // -------- video path
   // R18: clip to the active code range unless the matrix passes codes
   function automatic logic [9:0] clip(input logic [9:0] v, input logic [9:0] hi);
      if (v < `SLDM_CODE_MIN) clip = `SLDM_CODE_MIN;
      else if (v > hi)        clip = hi;
      else                    clip = v;
   endfunction

   // R24: bypass leaves input codes untouched
   wire         do_clip   = clip_en && !csm_byp;
   // R17: rgb keeps 64..940 on every channel
   wire [9:0]   c_max     = rgb_ofs ? `SLDM_CODE_Y_MAX : `SLDM_CODE_C_MAX;
   wire [9:0]   v0        = do_clip ? clip(video_i.ch0, `SLDM_CODE_Y_MAX) : video_i.ch0;
   wire [9:0]   v1        = do_clip ? clip(video_i.ch1, c_max) : video_i.ch1;
   wire [9:0]   v2        = do_clip ? clip(video_i.ch2, c_max) : video_i.ch2;
   // R12: rgb lifts all channels above the sync tip
   // R13: otherwise only luma gets the offset; chroma code 0 is bottom
   wire [10:0]  ofs_y     = (mode == SLDM_MODE_PC) ? 11'h000 : `SLDM_DAC_OFFSET;
   wire [10:0]  ofs_c     = ((mode != SLDM_MODE_PC) && rgb_ofs) ? `SLDM_DAC_OFFSET : 11'h000;
   wire [10:0]  vd0       = {1'b0, v0} + ofs_y;
   wire [10:0]  vd1       = {1'b0, v1} + ofs_c;
   wire [10:0]  vd2       = {1'b0, v2} + ofs_c;

   // -------- generated levels
   // R11: luma and chroma override levels are separate
   function automatic logic [10:0] gen_level(input sldm_levels_s lv, input logic ins,
                                             input logic lo, input logic hi);
      if (ins && lo)      gen_level = {1'b0, lv.low};
      else if (ins && hi) gen_level = {1'b0, lv.high};
      else                gen_level = {1'b0, lv.blank};
   endfunction

   // R19: channel 0 carries sync in sync-on-green
   // R23: channel 0 is luma in sync-on-luma
   // R22: no insertion at all without sync
   wire         ins0      = (sync_sel == SLDM_SYNC_ONE) || (sync_sel == SLDM_SYNC_ALL);
   // R20: other channels stay at blank unless all carry sync
   // R21: all-channel insertion gives one common format
   wire         ins12     = (sync_sel == SLDM_SYNC_ALL);
   wire [10:0]  g0        = gen_level(y_lev, ins0, sync_low, sync_high);
   wire [10:0]  g1        = gen_level(c_lev, ins12, sync_low, sync_high);
   wire [10:0]  g2        = gen_level(c_lev, ins12, sync_low, sync_high);

   // R15: three 11-bit dac words
   // R8: non-video line types take the generated levels
   sldm_dac_s   dac_d;
   assign dac_d.ch0 = use_video ? vd0 : g0;
   assign dac_d.ch1 = use_video ? vd1 : g1;
   assign dac_d.ch2 = use_video ? vd2 : g2;

   wire         vsync_d   = (ltype == double_broad_sync_line) ||
                            (ltype == equalization_then_broad_line) ||
                            (ltype == broad_then_equalization_line);

   wire [31:0]  status    = {20'h00000, field2, ltype, line_q[6:0]};
   wire [31:0]  rdata_d   =
      (reg_addr_i == `SLDM_REG_CTRL)      ? {23'h000000, ctrl_q} :
      (reg_addr_i == `SLDM_REG_Y_LEVELS)  ? {2'h0, y_lev_q} :
      (reg_addr_i == `SLDM_REG_C_LEVELS)  ? {2'h0, c_lev_q} :
      (reg_addr_i == `SLDM_REG_HTOTAL)    ? {20'h00000, htotal_q} :
      (reg_addr_i == `SLDM_REG_HSYNC_W)   ? {20'h00000, hsync_w_q} :
      (reg_addr_i == `SLDM_REG_ACT_START) ? {20'h00000, act_start_q} :
      (reg_addr_i == `SLDM_REG_ACT_END)   ? {20'h00000, act_end_q} :
      (reg_addr_i == `SLDM_REG_STATUS)    ? {status[31:17], line_q, status[6:0]} :
      32'h00000000;

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         ctrl_q      <= `SLDM_CTRL_RST;
         y_lev_q     <= `SLDM_Y_LEV_RST;
         c_lev_q     <= `SLDM_C_LEV_RST;
         htotal_q    <= `SLDM_HTOTAL_RST;
         hsync_w_q   <= `SLDM_HSYNC_W_RST;
         act_start_q <= `SLDM_ACT_START_RST;
         act_end_q   <= `SLDM_ACT_END_RST;
      end
      else
      begin
         if (wr_ctrl) ctrl_q      <= reg_wdata_i[`SLDM_CTRL_WIDTH-1:0];
         if (wr_ylev) y_lev_q     <= reg_wdata_i[29:0];
         if (wr_clev) c_lev_q     <= reg_wdata_i[29:0];
         if (wr_htot) htotal_q    <= reg_wdata_i[11:0];
         if (wr_hsw)  hsync_w_q   <= reg_wdata_i[11:0];
         if (wr_ast)  act_start_q <= reg_wdata_i[11:0];
         if (wr_aen)  act_end_q   <= reg_wdata_i[11:0];
      end
   end

   // R5: frame size preset
   // R6: field size preset
   always_ff @(posedge clk_sys_i)
   begin
      frame_size_q <= `SLDM_FRAME_SIZE;
      field_size_q <= `SLDM_FIELD_SIZE;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         pix_q   <= 12'h000;
         line_q  <= 10'h001;
         dac_q   <= '0;
         hsync_q <= 1'b0;
         vsync_q <= 1'b0;
         rdata_q <= 32'h00000000;
      end
      else
      begin
         pix_q   <= pix_last ? 12'h000 : pix_q + 12'h001;
         if (pix_last)
            line_q <= line_nxt;
         dac_q   <= dac_d;
         // R22: separate sync pins
         hsync_q <= (pulse == SLDM_PULSE_NORM) && !second && (hpos < hsync_w_q);
         vsync_q <= vsync_d;
         rdata_q <= reg_rd_i ? rdata_d : 32'h00000000;
      end
   end

   assign reg_rdata_o        = rdata_q;
   assign dac_o              = dac_q;
   assign hsync_output_pin_o = hsync_q;
   assign vsync_output_pin_o = vsync_q;
   // R16: full-scale range select
   assign full_scale_sel_o   = ctrl_q[`SLDM_CTRL_FSADJ];

   // -------- checks
   a_line_wrap: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R25
      (pix_last && line_q == 10'h20d) |=> (line_q == 10'h001))
      else $error("line counter did not wrap to 1");

   a_line_range: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R5
      (line_q >= 10'h001) && (line_q <= 10'h20d))
      else $error("line counter outside 1..525");

   a_field_split: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R7
      field2 == (line_q >= 10'h108))
      else $error("field flag wrong at field boundary");

   a_active_pass: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R1
      (ltype == active_video_line && in_act && !do_clip && mode == SLDM_MODE_SD)
      |=> (dac_o.ch0 == {1'b0, $past(video_i.ch0)} + `SLDM_DAC_OFFSET))
      else $error("active video not forwarded");

   a_gen_levels: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R8
      (mode != SLDM_MODE_PC && !passthru && ltype == double_broad_sync_line)
      |=> (dac_o.ch0 == {1'b0, $past(y_lev.low)} || dac_o.ch0 == {1'b0, $past(y_lev.blank)}
           || dac_o.ch0 == {1'b0, $past(y_lev.high)}))
      else $error("generated level not selected");

   a_pc_video: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R10
      (mode == SLDM_MODE_PC && csm_byp) |=> (dac_o.ch1 == {1'b0, $past(video_i.ch1)}))
      else $error("pc mode did not forward input");

   a_green_blank: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R20
      (!use_video && sync_sel == SLDM_SYNC_ONE) |=> (dac_o.ch2 == {1'b0, $past(c_lev.blank)}))
      else $error("red or blue channel left blank level during sync");

   a_no_sync: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R22
      (!use_video && sync_sel == SLDM_SYNC_NONE) |=> (dac_o.ch0 == {1'b0, $past(y_lev.blank)}))
      else $error("sync inserted while insertion is off");

   a_chroma_ofs: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R13
      (use_video && !rgb_ofs && csm_byp) |=> (dac_o.ch2 == {1'b0, $past(video_i.ch2)}))
      else $error("offset added to chroma in luma mode");

   a_luma_sync: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R23
      (!use_video && ins0 && sync_low) |=> (dac_o.ch0 == {1'b0, $past(y_lev.low)}))
      else $error("sync tip missing on channel 0");

   a_all_sync: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R21
      (!use_video && ins12 && sync_low)
      |=> (dac_o.ch1 == {1'b0, $past(c_lev.low)}) && (dac_o.ch2 == {1'b0, $past(c_lev.low)}))
      else $error("sync tip missing on channels 1 and 2");

   a_pass_opt: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R9
      (passthru && ltype == full_normal_sync_line && in_act) |=> (dac_o.ch0 == $past(vd0)))
      else $error("pass-through did not forward input");

   a_mix_gen: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R2
      (mode != SLDM_MODE_PC && ltype == active_then_equalization_line && second)
      |=> (dac_o.ch1 == $past(g1)))
      else $error("second half of mixed line not generated");

   a_vsync_pin: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R3
      (line_q >= 10'h004 && line_q < 10'h007) |=> vsync_output_pin_o)
      else $error("vertical sync pin low on broad lines");

   a_eq_lines: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R4
      (line_q >= 10'h10e && line_q < 10'h111) |=> !vsync_output_pin_o)
      else $error("vertical sync pin high on equalization lines");

   a_hsync_pin: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R22
      (pulse == SLDM_PULSE_BROAD) |=> !hsync_output_pin_o)
      else $error("horizontal sync pin high during broad pulse");

   a_clip_luma: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R18
      (do_clip && use_video && mode != SLDM_MODE_PC)
      |=> (dac_o.ch0 >= {1'b0, `SLDM_CODE_MIN} + `SLDM_DAC_OFFSET)
          && (dac_o.ch0 <= {1'b0, `SLDM_CODE_Y_MAX} + `SLDM_DAC_OFFSET))
      else $error("luma code outside clip range");

   a_pc_luma: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R10
      (mode == SLDM_MODE_PC && !do_clip) |=> (dac_o.ch0 == {1'b0, $past(video_i.ch0)}))
      else $error("pc mode altered luma input");

   a_rgb_chroma: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R12
      (use_video && rgb_ofs && mode == SLDM_MODE_SD && !do_clip)
      |=> (dac_o.ch1 == {1'b0, $past(video_i.ch1)} + `SLDM_DAC_OFFSET))
      else $error("rgb offset missing on channel 1");

endmodule
`default_nettype wire

// ### test/sldm_video_src.sv
`timescale 1ns/1ps
`default_nettype none

module sldm_video_src
   import sldm_pkg::*;
(
   input  wire logic  clk_i,
   output sldm_video_s video_o,
   output sldm_video_s prev_o
);
   logic [31:0] seed;
   sldm_video_s nxt;

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction

   // offset binary, blank to peak, plus codes 0 and 1023 past both ends
   function automatic logic [9:0] code(input logic [31:0] r);
      if (r[31:28] == 4'h0)
         return 10'd64;
      else if (r[31:28] == 4'h1)
         return 10'd940;
      else if (r[31:28] == 4'h2)
         return 10'h000;
      else if (r[31:28] == 4'h3)
         return 10'h3ff;
      return 10'(10'd64 + r % 877);
   endfunction

   // prev_o is what the dac stage saw last edge
   initial
   begin
      seed    = 32'h5b8f507b;
      video_o = {3{10'h040}};
      prev_o  = {3{10'h040}};
      forever
      begin
         @(posedge clk_i);
         seed = xs(seed);
         nxt.ch0 = code(seed);
         seed = xs(seed);
         nxt.ch1 = code(seed);
         seed = xs(seed);
         nxt.ch2 = code(seed);
         prev_o  <= video_o;
         video_o <= nxt;
      end
   end
endmodule

`default_nettype wire

// ### test/sdtv_line_sequence_dac_mux_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "sldm_defs.svh"

module sdtv_line_sequence_dac_mux_test
   import sldm_pkg::*;
;
   // short lines keep three frames well inside the run budget
   localparam int H  = 48;
   localparam int F  = 525 * H;
   localparam int SP = 30;
   localparam logic [9:0] YB = 10'h050, YL = 10'h010, YH = 10'h3a0;
   localparam logic [9:0] CB = 10'h210, CL = 10'h020, CH = 10'h3b0;

   logic        clk_sys_i;
   logic        rst_i;
   logic [3:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   sldm_video_s video;
   sldm_video_s prev;
   sldm_dac_s   dac;
   sldm_dac_s   e_dac;
   logic        hs;
   logic        vs;
   logic        fs;
   logic        run;
   int          cnt;
   int          fr;
   int          ln;
   int          bad_count;
   int          checks_done;
   logic [3:0]  ra [9];
   logic [31:0] rv [9];

   sldm_top i_sldm_top (
      .clk_sys_i          (clk_sys_i),
      .rst_i              (rst_i),
      .reg_addr_i         (reg_addr),
      .reg_wdata_i        (reg_wdata),
      .reg_wr_i           (reg_wr),
      .reg_rd_i           (reg_rd),
      .reg_rdata_o        (reg_rdata),
      .video_i            (video),
      .dac_o              (dac),
      .hsync_output_pin_o (hs),
      .vsync_output_pin_o (vs),
      .full_scale_sel_o   (fs)
   );

   sldm_video_src i_sldm_video_src (
      .clk_i   (clk_sys_i),
      .video_o (video),
      .prev_o  (prev)
   );

   initial clk_sys_i = 1'b0;
   always #12.5 clk_sys_i = ~clk_sys_i;

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr    <= 1'b0;
   endtask

   task automatic reg_read(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk_sys_i);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd   <= 1'b0;
      #1;
      check(reg_rdata, exp);
   endtask

   function automatic logic [10:0] lim(input logic [9:0] v, input logic [9:0] hi);
      return {1'b0, (v < 10'd64) ? 10'd64 : ((v > hi) ? hi : v)};
   endfunction

   // which dac word a mid-line sample must carry; 0 where not judged
   function automatic logic exp_dac(input int f, input int l, input sldm_video_s v,
                                    output sldm_dac_s e);
      logic act;
      logic nsp;
      act = (l >= 20 && l <= 262) || l >= 283;
      nsp = (l >= 10 && l <= 19) || (l >= 273 && l <= 281);
      exp_dac = 1'b1;
      if (f == 2)
         e = {1'b0, v.ch2, 1'b0, v.ch1, 1'b0, v.ch0};
      // video with offset on all channels in frame 0; clipped, offset on channel 0 only in frame 1
      else if (act || (f == 1 && nsp))
      begin
         e.ch0 = ((f == 1) ? lim(v.ch0, 10'd940) : {1'b0, v.ch0}) + `SLDM_DAC_OFFSET;
         e.ch1 = (f == 1) ? lim(v.ch1, 10'd960) : {1'b0, v.ch1} + `SLDM_DAC_OFFSET;
         e.ch2 = (f == 1) ? lim(v.ch2, 10'd960) : {1'b0, v.ch2} + `SLDM_DAC_OFFSET;
      end
      else if (nsp)
         e = {1'b0, CB, 1'b0, CB, 1'b0, YB};
      // broad pulse: channel 0 only in frame 0, all in frame 1
      else if (l >= 4 && l <= 6)
         e = {1'b0, ((f == 1) ? CL : CB), 1'b0, ((f == 1) ? CL : CB), 1'b0, YL};
      else
         exp_dac = 1'b0;
   endfunction

   always @(posedge clk_sys_i)
      if (run)
         cnt <= cnt + 1;

   always @(negedge clk_sys_i)
      if (run && cnt < 3 * F)
      begin
         fr = cnt / F;
         ln = (cnt % F) / H + 1;
         if (cnt % H == 2)
            check(hs, (ln >= 10 && ln <= 263) || ln >= 273);
         if (cnt % H == SP)
         begin
            if (exp_dac(fr, ln, prev, e_dac))
               check(dac, e_dac);
            if (fr < 2)
               check(vs, (ln >= 4 && ln <= 6) || (ln >= 266 && ln <= 269));
            check(fs, fr == 1);
         end
      end

   initial
   begin
      repeat (3 * F + 3000) @(posedge clk_sys_i);
      bad_count++;
      wrap_up();
   end

   initial
   begin
      ra = '{`SLDM_REG_CTRL, `SLDM_REG_Y_LEVELS, `SLDM_REG_C_LEVELS, `SLDM_REG_HTOTAL,
             `SLDM_REG_HSYNC_W, `SLDM_REG_ACT_START, `SLDM_REG_ACT_END, 4'h9, 4'hf};
      rv = '{32'(`SLDM_CTRL_RST), 32'(`SLDM_Y_LEV_RST), 32'(`SLDM_C_LEV_RST),
             32'(`SLDM_HTOTAL_RST), 32'(`SLDM_HSYNC_W_RST), 32'(`SLDM_ACT_START_RST),
             32'(`SLDM_ACT_END_RST), 32'h0, 32'h0};
      rst_i     = 1'b1;
      reg_addr  = 4'h0;
      reg_wdata = 32'h0;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      run       = 1'b0;
      cnt       = 0;
      bad_count = 0;
      checks_done = 0;
      repeat (2) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      run   <= 1'b1;
      for (int i = 0; i < 9; i++)
         reg_read(ra[i], rv[i]);
      // must land before line 1 reaches the new length
      reg_write(`SLDM_REG_HTOTAL, 32'd48);
      reg_write(`SLDM_REG_HSYNC_W, 32'd4);
      reg_write(`SLDM_REG_ACT_START, 32'd8);
      reg_write(`SLDM_REG_ACT_END, 32'd46);
      reg_write(`SLDM_REG_Y_LEVELS, {2'b00, YH, YL, YB});
      reg_write(`SLDM_REG_C_LEVELS, {2'b00, CH, CL, CB});
      // sync on channel 0 only for the first frame
      reg_write(`SLDM_REG_CTRL, 32'h000000d8);
      reg_write(4'ha, 32'hffffffff);
      reg_read(4'ha, 32'h0);
      reg_read(`SLDM_REG_Y_LEVELS, {2'b00, YH, YL, YB});
      while (cnt < F + 2)
         @(posedge clk_sys_i);
      // sd, colour difference, pass-through, sync on all, clipping, full scale
      reg_write(`SLDM_REG_CTRL, 32'h000001a4);
      while (cnt < 2 * F + 2)
         @(posedge clk_sys_i);
      // pc mode, matrix bypassed, no clipping
      reg_write(`SLDM_REG_CTRL, 32'h00000042);
      while (cnt < 3 * F)
         @(posedge clk_sys_i);
      wrap_up();
   end
endmodule

`default_nettype wire
